// ### hw/addr_former.sv
// Flash command address formation from 3-byte or 4-byte command address
`timescale 1ns/100ps
module addr_former
  import flash_prot_pkg::*;
(
  input  wire logic                  pclk,         // Clock
  input  wire logic                  presetn,      // Async reset, active low
  input  wire logic                  four_byte,    // Four-byte address enable
  input  wire logic                  upper_bank,   // Upper bank bit
  input  wire flash_prot_pkg::cmd_addr_t cmd_in,   // Raw command address
  output flash_prot_pkg::cmd_addr_t  addr_out      // Formed address, registered
);
  typedef struct packed {
    cmd_addr_t out;
  } form_state_t;

  form_state_t st_reg;
  form_state_t st_next;

  always_comb begin
    st_next           = st_reg;
    st_next.out.valid = cmd_in.valid;
    if (cmd_in.valid) begin
      if (four_byte) begin
        st_next.out.addr = cmd_in.addr;
      end else begin
        st_next.out.addr                   = {8'h00, cmd_in.addr[ADDR3_W-1:0]};
        st_next.out.addr[ADDR_UPPER_POS]   = upper_bank;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign addr_out = st_reg.out;
endmodule

// ### hw/flash_prot_pkg.sv
// Package: register map, field layout, reset values and carrier types of the protection block
package flash_prot_pkg;
  // Byte offsets of the APB register words
  localparam logic [7:0] OFS_BANK      = 8'h00;
  localparam logic [7:0] OFS_MODE_SEL  = 8'h04;
  localparam logic [7:0] OFS_PWD_LO    = 8'h08;
  localparam logic [7:0] OFS_PWD_HI    = 8'h0c;
  localparam logic [7:0] OFS_FREEZE    = 8'h10;
  localparam logic [7:0] OFS_SECT_SEL  = 8'h14;
  localparam logic [7:0] OFS_SECT_PERS = 8'h18;
  localparam logic [7:0] OFS_SECT_DYN  = 8'h1c;
  localparam logic [7:0] OFS_STORED_TP = 8'h20;
  localparam logic [7:0] OFS_WORK_TP   = 8'h24;
  localparam logic [7:0] OFS_STATUS    = 8'h28;

  // Field positions
  localparam int BANK_FOUR_BYTE_BIT = 7;
  localparam int BANK_UPPER_BIT     = 1;
  localparam int MODE_PWD_LOCK_BIT  = 2;
  localparam int MODE_PERS_LOCK_BIT = 1;
  localparam int FREEZE_BIT         = 0;
  localparam int SECTOR_LSB         = 18;
  localparam int SECTOR_W           = 8;
  localparam int SECTOR_CNT         = 256;
  localparam int ADDR3_W            = 24;
  localparam int ADDR_UPPER_POS     = 25;

  // Status word bit positions
  localparam int STAT_RUN_BIT  = 0;
  localparam int STAT_PWD_BIT  = 1;
  localparam int STAT_PERS_BIT = 2;

  // Widths and reset values
  localparam int MODE_W = 16;
  localparam int PWD_W  = 64;
  localparam int TP_W   = 8;
  localparam logic [7:0]        BANK_WR_MASK   = 8'h82;
  localparam logic [MODE_W-1:0] MODE_SEL_RST   = 16'hffff;
  localparam logic [PWD_W-1:0]  PWD_RST        = 64'hffff_ffff_ffff_ffff;
  localparam logic [TP_W-1:0]   STORED_TP_RST  = 8'h00;
  localparam logic [7:0]        SECT_PROTECTED = 8'h00;
  localparam logic [7:0]        SECT_OPEN      = 8'hff;

  // Flash command address request and formed answer
  typedef struct packed {
    logic        valid;
    logic [31:0] addr;
  } cmd_addr_t;

  // Program or erase permission query for one sector
  typedef struct packed {
    logic        valid;
    logic [31:0] addr;
  } pe_req_t;

  typedef struct packed {
    logic valid;
    logic granted;
  } pe_ans_t;

  typedef enum logic [1:0] {
    ST_INIT = 2'b00,
    ST_RUN  = 2'b01
  } init_state_t;
endpackage

// ### hw/flash_protect_addr_regs.sv
// Address extension, sector protection and training pattern registers behind APB
//
// Chosen here: the register offsets and the APB interface to the registers.
`timescale 1ns/100ps
module flash_protect_addr_regs
  import flash_prot_pkg::*;
(
  input  wire logic                      pclk,             // APB clock, 100 MHz
  input  wire logic                      presetn,          // Async reset, active low
  input  wire logic                      psel,             // APB select
  input  wire logic                      penable,          // APB access phase
  input  wire logic                      pwrite,           // APB direction, 1 = write
  input  wire logic [7:0]                paddr,            // APB byte address
  input  wire logic [31:0]               pwdata,           // APB write data
  output logic      [31:0]               prdata,           // APB read data, registered
  output logic                           pready,           // APB ready
  output logic                           pslverr,          // APB error
  input  wire flash_prot_pkg::cmd_addr_t cmd_addr,         // Command address from decoder
  output flash_prot_pkg::cmd_addr_t      formed_addr,      // Address into the array
  input  wire flash_prot_pkg::pe_req_t   pe_req,           // Program or erase query
  output flash_prot_pkg::pe_ans_t        pe_ans,           // Query answer, registered
  output logic      [TP_W-1:0]           training_pattern, // Pattern for DDR dummy cycles
  output logic                           init_done         // Reset copy-in finished
);
  import flash_prot_pkg::*;

  typedef struct packed {
    init_state_t             phase;
    logic                    four_byte_address_enable;
    logic                    upper_bank_bit;
    logic                    persistent_bits_freeze;
    logic [SECTOR_W-1:0]     sector_sel;
    logic [SECTOR_CNT-1:0]   persistent_sector_bit;
    logic [SECTOR_CNT-1:0]   dynamic_sector_bit;
    logic [TP_W-1:0]         working_training_pattern;
    logic [31:0]             rdata;
    pe_ans_t                 ans;
  } regs_state_t;

  regs_state_t st_reg;
  regs_state_t st_next;

  logic [MODE_W-1:0] protection_mode_select;
  logic [PWD_W-1:0]  hidden_password;
  logic [TP_W-1:0]   stored_training_pattern;
  logic [31:0]       rd_word;

  logic setup_ph;
  logic access_ph;
  logic wr_ok;
  logic refused;
  logic mapped;
  logic pwd_mode;
  logic wr_mode;
  logic wr_pwd_lo;
  logic wr_pwd_hi;
  logic wr_tp;

  // Byte value that stands for one sector's protection bit
  function automatic logic [7:0] sect_byte(input logic bit_val);
    return bit_val ? SECT_OPEN : SECT_PROTECTED;
  endfunction

  // Sector number of a formed flash address
  function automatic logic [SECTOR_W-1:0] sect_of(input logic [31:0] a);
    return a[SECTOR_LSB +: SECTOR_W];
  endfunction

  // Password mode is on once its lock bit has been programmed to zero
  function automatic logic pwd_mode_of(input logic [MODE_W-1:0] mode);
    return !mode[MODE_PWD_LOCK_BIT];
  endfunction

  // Persistent mode is locked once its lock bit has been programmed to zero
  function automatic logic pers_mode_of(input logic [MODE_W-1:0] mode);
    return !mode[MODE_PERS_LOCK_BIT];
  endfunction

  // Read-only status word: run flag and the two permanent mode locks
  function automatic logic [31:0] status_word(input logic run, input logic [MODE_W-1:0] mode);
    logic [31:0] w;
    w                = '0;
    w[STAT_RUN_BIT]  = run;
    w[STAT_PWD_BIT]  = pwd_mode_of(mode);
    w[STAT_PERS_BIT] = pers_mode_of(mode);
    return w;
  endfunction

  assign setup_ph  = psel && !penable;
  assign access_ph = psel && penable;
  assign pwd_mode  = pwd_mode_of(protection_mode_select);

  always_comb begin
    unique case (paddr)
      OFS_BANK, OFS_MODE_SEL, OFS_PWD_LO, OFS_PWD_HI, OFS_FREEZE, OFS_SECT_SEL,
      OFS_SECT_PERS, OFS_SECT_DYN, OFS_STORED_TP, OFS_WORK_TP, OFS_STATUS: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  // Refused writes: frozen persistent bits, password once hidden, status word
  always_comb begin
    refused = 1'b0;
    if (pwrite) begin
      unique case (paddr)
        OFS_SECT_PERS: refused = !st_reg.persistent_bits_freeze;
        OFS_PWD_LO, OFS_PWD_HI: refused = pwd_mode;
        OFS_STATUS: refused = 1'b1;
        default: refused = 1'b0;
      endcase
    end
  end

  // Zero wait states; the read word was latched in the setup cycle
  assign pready  = 1'b1;
  assign pslverr = access_ph && (!mapped || refused);
  assign wr_ok   = access_ph && pwrite && mapped && !refused && (st_reg.phase == ST_RUN);

  assign wr_mode   = wr_ok && (paddr == OFS_MODE_SEL);
  assign wr_pwd_lo = wr_ok && (paddr == OFS_PWD_LO);
  assign wr_pwd_hi = wr_ok && (paddr == OFS_PWD_HI);
  assign wr_tp     = wr_ok && (paddr == OFS_STORED_TP);

  otp_clear_reg #(
    .WIDTH (MODE_W),
    .RST   (MODE_SEL_RST)
  ) u_mode_sel (
    .pclk    (pclk),
    .presetn (presetn),
    .wr_en   (wr_mode),
    .wr_data (pwdata[MODE_W-1:0]),
    .value   (protection_mode_select)
  );

  otp_clear_reg #(
    .WIDTH (PWD_W / 2),
    .RST   (PWD_RST[PWD_W/2-1:0])
  ) u_pwd_lo (
    .pclk    (pclk),
    .presetn (presetn),
    .wr_en   (wr_pwd_lo),
    .wr_data (pwdata),
    .value   (hidden_password[PWD_W/2-1:0])
  );

  otp_clear_reg #(
    .WIDTH (PWD_W / 2),
    .RST   (PWD_RST[PWD_W-1:PWD_W/2])
  ) u_pwd_hi (
    .pclk    (pclk),
    .presetn (presetn),
    .wr_en   (wr_pwd_hi),
    .wr_data (pwdata),
    .value   (hidden_password[PWD_W-1:PWD_W/2])
  );

  otp_clear_reg #(
    .WIDTH (TP_W),
    .RST   (STORED_TP_RST)
  ) u_stored_tp (
    .pclk    (pclk),
    .presetn (presetn),
    .wr_en   (wr_tp),
    .wr_data (pwdata[TP_W-1:0]),
    .value   (stored_training_pattern)
  );

  addr_former u_addr (
    .pclk       (pclk),
    .presetn    (presetn),
    .four_byte  (st_reg.four_byte_address_enable),
    .upper_bank (st_reg.upper_bank_bit),
    .cmd_in     (cmd_addr),
    .addr_out   (formed_addr)
  );

  // Read word of the addressed register; latched at the setup edge so that
  // prdata is already steady when the access phase samples it
  always_comb begin
    rd_word = '0;
    unique case (paddr)
      OFS_BANK: begin
        rd_word[BANK_FOUR_BYTE_BIT] = st_reg.four_byte_address_enable;
        rd_word[BANK_UPPER_BIT]     = st_reg.upper_bank_bit;
      end
      OFS_MODE_SEL: begin
        rd_word[MODE_W-1:0] = protection_mode_select;
      end
      OFS_PWD_LO: begin
        if (!pwd_mode) begin
          rd_word = hidden_password[PWD_W/2-1:0];
        end
      end
      OFS_PWD_HI: begin
        if (!pwd_mode) begin
          rd_word = hidden_password[PWD_W-1:PWD_W/2];
        end
      end
      OFS_FREEZE: begin
        rd_word[FREEZE_BIT] = st_reg.persistent_bits_freeze;
      end
      OFS_SECT_SEL: begin
        rd_word[SECTOR_W-1:0] = st_reg.sector_sel;
      end
      OFS_SECT_PERS: begin
        rd_word[7:0] = sect_byte(st_reg.persistent_sector_bit[st_reg.sector_sel]);
      end
      OFS_SECT_DYN: begin
        rd_word[7:0] = sect_byte(st_reg.dynamic_sector_bit[st_reg.sector_sel]);
      end
      OFS_STORED_TP: begin
        rd_word[TP_W-1:0] = stored_training_pattern;
      end
      OFS_WORK_TP: begin
        rd_word[TP_W-1:0] = st_reg.working_training_pattern;
      end
      OFS_STATUS: begin
        rd_word = status_word(st_reg.phase == ST_RUN, protection_mode_select);
      end
      default: rd_word = '0;
    endcase
  end

  always_comb begin
    st_next           = st_reg;
    st_next.ans.valid = 1'b0;

    unique case (st_reg.phase)
      // One cycle after release: modes are settled, derive the volatile copies
      ST_INIT: begin
        st_next.persistent_bits_freeze   = !pwd_mode;
        st_next.working_training_pattern = stored_training_pattern;
        st_next.phase                    = ST_RUN;
      end
      ST_RUN: begin
        if (wr_ok) begin
          unique case (paddr)
            OFS_BANK: begin
              st_next.four_byte_address_enable = pwdata[BANK_FOUR_BYTE_BIT];
              st_next.upper_bank_bit           = pwdata[BANK_UPPER_BIT];
            end
            OFS_FREEZE: begin
              // Can only be cleared; a reset is the way back unless password mode is on
              if (!pwdata[FREEZE_BIT]) begin
                st_next.persistent_bits_freeze = 1'b0;
              end
            end
            OFS_SECT_SEL: st_next.sector_sel = pwdata[SECTOR_W-1:0];
            OFS_SECT_PERS: begin
              st_next.persistent_sector_bit[st_reg.sector_sel] = (pwdata[7:0] != SECT_PROTECTED);
            end
            OFS_SECT_DYN: begin
              st_next.dynamic_sector_bit[st_reg.sector_sel] = (pwdata[7:0] != SECT_PROTECTED);
            end
            OFS_WORK_TP: st_next.working_training_pattern = pwdata[TP_W-1:0];
            default: ;
          endcase
        end

        if (pe_req.valid) begin
          st_next.ans.valid   = 1'b1;
          st_next.ans.granted = st_reg.persistent_sector_bit[sect_of(pe_req.addr)] &&
                                st_reg.dynamic_sector_bit[sect_of(pe_req.addr)];
        end
      end
      default: st_next.phase = ST_INIT;
    endcase

    if (setup_ph && !pwrite) begin
      st_next.rdata = rd_word;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg.phase                    <= ST_INIT;
      st_reg.four_byte_address_enable <= 1'b0;
      st_reg.upper_bank_bit           <= 1'b0;
      st_reg.persistent_bits_freeze   <= 1'b1;
      st_reg.sector_sel               <= '0;
      // Non-volatile in a real part; here the persistent bits also return to erased
      st_reg.persistent_sector_bit    <= '1;
      st_reg.dynamic_sector_bit       <= '1;
      st_reg.working_training_pattern <= STORED_TP_RST;
      st_reg.rdata                    <= '0;
      st_reg.ans                      <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign prdata           = st_reg.rdata;
  assign pe_ans           = st_reg.ans;
  assign training_pattern = st_reg.working_training_pattern;
  assign init_done        = (st_reg.phase == ST_RUN);
endmodule

// ### hw/otp_clear_reg.sv
// One-time-programmable word: bits can only be programmed from 1 to 0
`timescale 1ns/100ps
module otp_clear_reg #(
  parameter int                WIDTH = 8,
  parameter logic [WIDTH-1:0]  RST   = '1
) (
  input  wire logic             pclk,     // Clock
  input  wire logic             presetn,  // Async reset, active low
  input  wire logic             wr_en,    // Program strobe
  input  wire logic [WIDTH-1:0] wr_data,  // Zero bits get programmed
  output logic      [WIDTH-1:0] value     // Stored word
);
  typedef struct packed {
    logic [WIDTH-1:0] word;
  } otp_state_t;

  otp_state_t st_reg;
  otp_state_t st_next;

  // Only clearing is possible, so a second write can never undo the first
  always_comb begin
    st_next = st_reg;
    if (wr_en) begin
      st_next.word = st_reg.word & wr_data;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg.word <= RST;
    end else begin
      st_reg <= st_next;
    end
  end

  assign value = st_reg.word;
endmodule

// ### tb/flash_prot_monitor.sv
// Checker: port-level properties of the protection register block
`timescale 1ns/100ps
module flash_prot_monitor
  import flash_prot_pkg::*;
(
  input wire logic                      pclk,             // Clock
  input wire logic                      presetn,          // Reset, active low
  input wire logic                      psel,             // APB select
  input wire logic                      penable,          // APB enable
  input wire logic                      pwrite,           // APB direction
  input wire logic [7:0]                paddr,            // APB address
  input wire logic [31:0]               pwdata,           // APB write data
  input wire logic [31:0]               prdata,           // APB read data
  input wire logic                      pready,           // APB ready
  input wire logic                      pslverr,          // APB error
  input wire flash_prot_pkg::cmd_addr_t cmd_addr,         // Raw address
  input wire flash_prot_pkg::cmd_addr_t formed_addr,      // Formed address
  input wire flash_prot_pkg::pe_req_t   pe_req,           // Query
  input wire flash_prot_pkg::pe_ans_t   pe_ans,           // Answer
  input wire logic [TP_W-1:0]           training_pattern, // Pattern
  input wire logic                      init_done         // Init finished
);
  logic       wr;
  logic [7:0] bank_reg;
  logic       pwd_reg;
  logic       frz_reg;
  assign wr = psel && penable && pwrite && pready && init_done && !pslverr;
  // Shadows of the few register bits the properties depend on
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bank_reg <= 8'h00;
      pwd_reg  <= 1'b0;
      frz_reg  <= 1'b1;
    end else if (wr) begin
      if (paddr == OFS_BANK) bank_reg <= pwdata[7:0] & BANK_WR_MASK;
      if (paddr == OFS_MODE_SEL && !pwdata[MODE_PWD_LOCK_BIT]) pwd_reg <= 1'b1;
      if (paddr == OFS_FREEZE && !pwdata[FREEZE_BIT]) frz_reg <= 1'b0;
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  AST_ADDR32: assert property (cmd_addr.valid && bank_reg[BANK_FOUR_BYTE_BIT]
    |=> formed_addr.valid && formed_addr.addr == $past(cmd_addr.addr)) else $error("full address not kept");
  AST_ADDR24: assert property (cmd_addr.valid && !bank_reg[BANK_FOUR_BYTE_BIT] |=>
    formed_addr.addr == {6'h00, $past(bank_reg[1]), 1'b0, $past(cmd_addr.addr[23:0])}) else $error("bad 3-byte address");
  AST_FORMED_ONLY: assert property (formed_addr.valid |-> $past(cmd_addr.valid))
    else $error("formed address without request");
  AST_PE_ANS: assert property (pe_req.valid && init_done |=> pe_ans.valid)
    else $error("query not answered");
  AST_PWD_HIDDEN: assert property (psel && penable && !pwrite && pwd_reg &&
    (paddr == OFS_PWD_LO || paddr == OFS_PWD_HI) |-> prdata == 32'h0000_0000) else $error("password readable");
  AST_FREEZE_REFUSE: assert property (psel && penable && pwrite && !frz_reg
    && paddr == OFS_SECT_PERS |-> pslverr) else $error("frozen persistent write accepted");
  AST_TP_FOLLOW: assert property (wr && paddr == OFS_WORK_TP
    |=> training_pattern == $past(pwdata[7:0])) else $error("pattern not updated");
  AST_TP_RESET: assert property ($rose(init_done) |-> training_pattern == STORED_TP_RST)
    else $error("pattern not copied at reset");
endmodule

bind flash_protect_addr_regs flash_prot_monitor mon_u (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .cmd_addr(cmd_addr), .formed_addr(formed_addr), .pe_req(pe_req), .pe_ans(pe_ans),
  .training_pattern(training_pattern), .init_done(init_done));

// ### tb/flash_protect_addr_regs_tb_top.sv
// Testbench: APB register tests plus command address and protection queries
`timescale 1ns/100ps
module flash_protect_addr_regs_tb_top;
  import flash_prot_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, init_done;
  logic [7:0]  paddr, training_pattern;
  logic [31:0] pwdata, prdata;
  cmd_addr_t   cmd_addr, formed_addr;
  pe_req_t     pe_req;
  pe_ans_t     pe_ans;
  int          errors = 0;
  int          comparisons = 0;

  flash_protect_addr_regs dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cmd_addr(cmd_addr), .formed_addr(formed_addr), .pe_req(pe_req), .pe_ans(pe_ans),
    .training_pattern(training_pattern), .init_done(init_done));
  host_cmd_model host_u (.pclk(pclk), .cmd_addr(cmd_addr), .pe_req(pe_req), .formed_addr(formed_addr),
    .pe_ans(pe_ans));

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  task automatic tally_and_finish;
    $display("comparisons=%0d errors=%0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d, output logic [31:0] q,
                     output logic e);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) errors++;
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic ee);
    logic [31:0] q;
    logic        e;
    apb(a, 1'b1, d, q, e);
    check({31'h0, e}, {31'h0, ee});
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input logic ee);
    logic [31:0] q;
    logic        e;
    apb(a, 1'b0, 32'h0, q, e);
    check(q, exp);
    check({31'h0, e}, {31'h0, ee});
  endtask
  task automatic addr_chk(input logic [31:0] a, input logic [31:0] exp);
    cmd_addr_t f;
    host_u.send_addr(a, f);
    check({f.valid, f.addr[31:1]}, {1'b1, exp[31:1]});
    check(f.addr, exp);
  endtask
  task automatic query(input logic [7:0] s, input logic g);
    pe_ans_t r;
    host_u.query({6'h00, s, 18'h00000}, r);
    check({30'h0, r.valid, r.granted}, {30'h0, 1'b1, g});
  endtask
  task automatic do_reset;
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    check({31'h0, init_done}, 32'h1);
  endtask

  initial begin
    #100000;
    errors++;
    tally_and_finish;
  end

  initial begin
    presetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    do_reset;
    rdc(OFS_BANK, 32'h0, 1'b0);
    rdc(OFS_MODE_SEL, 32'h0000_ffff, 1'b0);
    rdc(OFS_PWD_LO, 32'hffff_ffff, 1'b0);
    rdc(OFS_FREEZE, 32'h1, 1'b0);
    rdc(OFS_SECT_PERS, 32'hff, 1'b0);
    rdc(OFS_SECT_DYN, 32'hff, 1'b0);
    rdc(OFS_STORED_TP, 32'h0, 1'b0);
    rdc(OFS_WORK_TP, 32'h0, 1'b0);
    rdc(OFS_STATUS, 32'h1, 1'b0);
    rdc(8'h2c, 32'h0, 1'b1);
    $display("test reset values done");
    wr(OFS_BANK, 32'hff, 1'b0);
    rdc(OFS_BANK, 32'h82, 1'b0);
    addr_chk(32'hfedc_ba98, 32'hfedc_ba98);
    wr(OFS_BANK, 32'h02, 1'b0);
    addr_chk(32'hfedc_ba98, 32'h02dc_ba98);
    wr(OFS_BANK, 32'h00, 1'b0);
    addr_chk(32'hffff_ffff, 32'h00ff_ffff);
    $display("test address done");
    wr(OFS_SECT_SEL, 32'h5, 1'b0);
    query(8'h05, 1'b1);
    wr(OFS_SECT_DYN, 32'h0, 1'b0);
    rdc(OFS_SECT_DYN, 32'h0, 1'b0);
    query(8'h05, 1'b0);
    query(8'h06, 1'b1);
    wr(OFS_SECT_DYN, 32'hff, 1'b0);
    wr(OFS_SECT_PERS, 32'h0, 1'b0);
    rdc(OFS_SECT_PERS, 32'h0, 1'b0);
    query(8'h05, 1'b0);
    wr(OFS_SECT_PERS, 32'hff, 1'b0);
    rdc(OFS_SECT_PERS, 32'hff, 1'b0);
    query(8'h05, 1'b1);
    $display("test sectors done");
    wr(OFS_FREEZE, 32'h0, 1'b0);
    rdc(OFS_FREEZE, 32'h0, 1'b0);
    wr(OFS_SECT_PERS, 32'h0, 1'b1);
    rdc(OFS_SECT_PERS, 32'hff, 1'b0);
    wr(OFS_STORED_TP, 32'h3c, 1'b0);
    rdc(OFS_STORED_TP, 32'h0, 1'b0);
    wr(OFS_WORK_TP, 32'ha5, 1'b0);
    rdc(OFS_WORK_TP, 32'ha5, 1'b0);
    check({24'h0, training_pattern}, 32'ha5);
    do_reset;
    rdc(OFS_FREEZE, 32'h1, 1'b0);
    rdc(OFS_WORK_TP, 32'h0, 1'b0);
    check({24'h0, training_pattern}, 32'h0);
    $display("test freeze and pattern done");
    wr(OFS_PWD_LO, 32'h1234_5678, 1'b0);
    wr(OFS_PWD_HI, 32'h9abc_def0, 1'b0);
    rdc(OFS_PWD_LO, 32'h1234_5678, 1'b0);
    rdc(OFS_PWD_HI, 32'h9abc_def0, 1'b0);
    wr(OFS_MODE_SEL, 32'hfffd, 1'b0);
    rdc(OFS_MODE_SEL, 32'hfffd, 1'b0);
    rdc(OFS_STATUS, 32'h5, 1'b0);
    wr(OFS_MODE_SEL, 32'hfffb, 1'b0);
    rdc(OFS_STATUS, 32'h7, 1'b0);
    rdc(OFS_PWD_LO, 32'h0, 1'b0);
    rdc(OFS_PWD_HI, 32'h0, 1'b0);
    wr(OFS_PWD_LO, 32'h0, 1'b1);
    wr(OFS_MODE_SEL, 32'hffff, 1'b0);
    rdc(OFS_MODE_SEL, 32'hfff9, 1'b0);
    $display("test protection modes done");
    tally_and_finish;
  end
endmodule

// ### tb/host_cmd_model.sv
// Host side model: issues command addresses and program/erase queries
`timescale 1ns/100ps
module host_cmd_model
  import flash_prot_pkg::*;
(
  input  wire logic                      pclk,        // Clock
  output flash_prot_pkg::cmd_addr_t      cmd_addr,    // Command address out
  output flash_prot_pkg::pe_req_t        pe_req,      // Query out
  input  wire flash_prot_pkg::cmd_addr_t formed_addr, // Formed address back
  input  wire flash_prot_pkg::pe_ans_t   pe_ans       // Answer back
);
  initial begin
    cmd_addr = '0;
    pe_req   = '0;
  end
  // Released addresses are inverted so a stale capture cannot pass
  task automatic send_addr(input logic [31:0] a, output cmd_addr_t f);
    @(posedge pclk);
    cmd_addr <= '{valid: 1'b1, addr: a};
    @(posedge pclk);
    cmd_addr <= '{valid: 1'b0, addr: ~a};
    #1;
    f = formed_addr;
  endtask
  task automatic query(input logic [31:0] a, output pe_ans_t r);
    @(posedge pclk);
    pe_req <= '{valid: 1'b1, addr: a};
    @(posedge pclk);
    pe_req <= '{valid: 1'b0, addr: ~a};
    #1;
    r = pe_ans;
  endtask
endmodule
